// ===== src/sbc_regs.vh
// Constants of the stepper bridge control block: register map, fields,
// reset values, indexer table positions and decay codes.
// Assumes inclusion by bare name from the design files under src/.
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// Register byte offsets on the AXI4-Lite port
`define SBC_OFF_CTRL      8'h00
`define SBC_OFF_POSITION  8'h04
`define SBC_OFF_CURRENT   8'h08
`define SBC_OFF_PINS      8'h0c

// Control register fields and reset value
`define SBC_CTRL_INDEXER  0
`define SBC_CTRL_SLEEP    1
`define SBC_CTRL_RST      2'h0

// Status field positions
`define SBC_POS_RES_LSB   8
`define SBC_CUR_B_LSB     8

// Indexer positions, 128 entries per electrical cycle
`define SBC_HOME_POS      7'h10
`define SBC_QUARTER       7'h20
`define SBC_FULL_OFFSET   7'h10
`define SBC_MAX_STEP      8'h20

// Resolution codes
`define SBC_RES_FULL      3'h0
`define SBC_RES_HALF      3'h1
`define SBC_RES_QUARTER   3'h2
`define SBC_RES_EIGHTH    3'h3
`define SBC_RES_SIXTEENTH 3'h4
`define SBC_RES_THIRTY2   3'h5

// Current and decay codes
`define SBC_FULL_SCALE    7'h64
`define SBC_DECAY_SLOW    3'h0

// AXI responses
`define SBC_RESP_OKAY     2'h0
`define SBC_RESP_SLVERR   2'h2

`endif

// ===== src/sbc_sync.v
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level from outside the aclk domain.
module sbc_sync #(
    parameter WIDTH = 16
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] d_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign d_out = sync_q;

endmodule // sbc_sync

// ===== src/sbc_top.v
// Stepper bridge control: phase/enable decoder, microstepping indexer
// and AXI4-Lite register slave for a dual H-bridge power stage.
// Assumes all pins are asynchronous to aclk; the power stage reads the
// registered bridge levels, enables, current and decay commands.
`include "sbc_regs.vh"

// Functional notes
// - Phase/enable: current direction follows winding_direction.
// - Phase/enable: bridge drives current only while bridge_enable_in is high.
// - Disabled bridge with mode_select_hi high: both outputs high impedance.
// - Disabled bridge with mode_select_hi low: both outputs driven low.
// - Enabled: direction 0 gives pos low/neg high, 1 gives pos high/neg low.
// - Indexer advances one state per step_pulse rising edge, per travel_dir.
// - Indexer: output_disable_n high disables outputs; stepping goes on.
// - Resolution from hi/lo: 00 full,01 half,0Z quarter,10,11,1Z finer.
// - mode_select_lo is three-level: low, high or floating.
// - Mode selects are sampled at each step_pulse rising edge.
// - After a resolution change the next step lands on a valid state.
// - Indexer goes home (45 degrees) after reset, undervoltage and sleep.
// - travel_dir high steps up the table, low steps down.
// - Positive table current drives bridge_out_pos above bridge_out_neg.
// - Finest resolution walks the 128-entry sine/cosine current table.
// - Coarser resolutions visit subsets; full step uses 45-degree points.
// - Indexer drives both bridges from the table position alone.
// - Indexer uses decay_select_a; slow decay forced while magnitude rises.
// - Undervoltage disables outputs and resets the indexer state.
module sbc_top #(
    parameter ADDR_W = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              winding_direction_a,
    input  wire              winding_direction_b,
    input  wire              bridge_enable_in_a,
    input  wire              bridge_enable_in_b,
    input  wire              mode_select_hi,
    input  wire              mode_select_lo,
    input  wire              mode_select_lo_float,
    input  wire              step_pulse,
    input  wire              travel_dir,
    input  wire              output_disable_n,
    input  wire              undervolt_n,
    input  wire [2:0]        decay_select_a,
    input  wire [2:0]        decay_select_b,
    output reg               bridge_out_pos_a,
    output reg               bridge_out_pos_a_oe,
    output reg               bridge_out_neg_a,
    output reg               bridge_out_neg_a_oe,
    output reg               bridge_out_pos_b,
    output reg               bridge_out_pos_b_oe,
    output reg               bridge_out_neg_b,
    output reg               bridge_out_neg_b_oe,
    output reg  [6:0]        current_cmd_a,
    output reg  [6:0]        current_cmd_b,
    output reg  [2:0]        decay_mode_a,
    output reg  [2:0]        decay_mode_b
);

    // Pin synchronisation
    wire [16:0] pins_s;
    sbc_sync #(.WIDTH(17)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d_in    ({decay_select_b, decay_select_a, undervolt_n,
                   output_disable_n, travel_dir, step_pulse,
                   mode_select_lo_float, mode_select_lo, mode_select_hi,
                   bridge_enable_in_b, bridge_enable_in_a,
                   winding_direction_b, winding_direction_a}),
        .d_out   (pins_s)
    );
    wire       dir_a_s  = pins_s[0];
    wire       dir_b_s  = pins_s[1];
    wire       en_a_s   = pins_s[2];
    wire       en_b_s   = pins_s[3];
    wire       m_hi_s   = pins_s[4];
    wire       m_lo_s   = pins_s[5];
    wire       m_lz_s   = pins_s[6];
    wire       step_s   = pins_s[7];
    wire       tdir_s   = pins_s[8];
    wire       odis_s   = pins_s[9];
    wire       uv_n_s   = pins_s[10];
    wire [2:0] dec_a_s  = pins_s[13:11];
    wire [2:0] dec_b_s  = pins_s[16:14];

    reg  [1:0] ctrl_q;
    reg        step_d_q;
    reg  [6:0] pos_q;
    reg  [6:0] pos_d;
    reg  [6:0] prev_q;
    reg  [2:0] res_q;
    reg  [2:0] res_d;

    wire indexer_mode = ctrl_q[`SBC_CTRL_INDEXER];
    wire asleep       = ctrl_q[`SBC_CTRL_SLEEP];
    wire hold_home    = asleep | ~uv_n_s;
    wire step_rise    = step_s & ~step_d_q;

    // Cosine magnitude in percent over one quarter, 33 points
    function [6:0] mag;
        input [5:0] t;
        begin
            case (t)
                6'd0, 6'd1, 6'd2: mag = 7'd100;
                6'd3:  mag = 7'd99;  6'd4:  mag = 7'd98;
                6'd5:  mag = 7'd97;  6'd6:  mag = 7'd96;
                6'd7:  mag = 7'd94;  6'd8:  mag = 7'd92;
                6'd9:  mag = 7'd90;  6'd10: mag = 7'd88;
                6'd11: mag = 7'd86;  6'd12: mag = 7'd83;
                6'd13: mag = 7'd80;  6'd14: mag = 7'd77;
                6'd15: mag = 7'd74;  6'd16: mag = 7'd71;
                6'd17: mag = 7'd67;  6'd18: mag = 7'd63;
                6'd19: mag = 7'd60;  6'd20: mag = 7'd56;
                6'd21: mag = 7'd51;  6'd22: mag = 7'd47;
                6'd23: mag = 7'd43;  6'd24: mag = 7'd38;
                6'd25: mag = 7'd34;  6'd26: mag = 7'd29;
                6'd27: mag = 7'd24;  6'd28: mag = 7'd20;
                6'd29: mag = 7'd15;  6'd30: mag = 7'd10;
                6'd31: mag = 7'd5;
                default: mag = 7'd0;
            endcase
        end
    endfunction

    // Signed cosine current of a table index, two's complement
    function [7:0] cosine;
        input [6:0] i;
        reg   [6:0] m;
        begin
            m = 7'd0;
            if (i[5])
                m = mag(6'd32 - {1'b0, i[4:0]});
            else
                m = mag({1'b0, i[4:0]});
            if (i[6] ^ i[5])
                cosine = 8'h00 - {1'b0, m};
            else
                cosine = {1'b0, m};
        end
    endfunction

    // Magnitude of a signed current
    function [6:0] absval;
        input [7:0] v;
        reg   [7:0] n;
        begin
            n = 8'h00 - v;
            absval = v[7] ? n[6:0] : v[6:0];
        end
    endfunction

    // Winding B lags winding A by a quarter cycle
    wire [7:0] cur_a = cosine(pos_q);
    wire [7:0] cur_b = cosine(pos_q - `SBC_QUARTER);
    wire [7:0] prv_a = cosine(prev_q);
    wire [7:0] prv_b = cosine(prev_q - `SBC_QUARTER);
    wire rise_a = absval(cur_a) > absval(prv_a);
    wire rise_b = absval(cur_b) > absval(prv_b);

    // Resolution decode and next valid position
    reg  [7:0] sz;
    reg  [6:0] off;
    reg  [6:0] rel;
    reg  [6:0] base;
    always @* begin
        sz   = 8'h00;
        off  = 7'h00;
        rel  = 7'h00;
        base = 7'h00;
        // Floating lo selects the finest-of-three slot in each half
        if (m_lz_s)
            res_d = m_hi_s ? `SBC_RES_THIRTY2 : `SBC_RES_QUARTER;
        else
            res_d = {1'b0, m_hi_s, 1'b0} + {2'b00, m_lo_s} +
                    {1'b0, m_hi_s, 1'b0} - {2'b00, m_hi_s};
        sz   = `SBC_MAX_STEP >> res_d;
        // Full step keeps to the 45-degree points
        off  = (res_d == `SBC_RES_FULL) ? `SBC_FULL_OFFSET : 7'h00;
        rel  = pos_q - off;
        base = rel & ~(sz[6:0] - 7'h01);
        // Rounding onto the new grid lands on a valid state
        if (tdir_s)
            pos_d = base + sz[6:0] + off;
        else if (rel == base)
            pos_d = base - sz[6:0] + off;
        else
            pos_d = base + off;
    end

    // Indexer state; steps count even with the outputs disabled
    always @(posedge aclk) begin
        if (!aresetn) begin
            step_d_q <= 1'b0;
            pos_q    <= `SBC_HOME_POS;
            prev_q   <= `SBC_HOME_POS;
            res_q    <= `SBC_RES_FULL;
        end else begin
            step_d_q <= step_s;
            if (hold_home) begin
                pos_q  <= `SBC_HOME_POS;
                prev_q <= `SBC_HOME_POS;
            end else if (indexer_mode && step_rise) begin
                pos_q  <= pos_d;
                prev_q <= pos_q;
                res_q  <= res_d;
            end
        end
    end

    // Bridge outputs, currents and decay, registered toward the stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            bridge_out_pos_a    <= 1'b0;
            bridge_out_neg_a    <= 1'b0;
            bridge_out_pos_b    <= 1'b0;
            bridge_out_neg_b    <= 1'b0;
            bridge_out_pos_a_oe <= 1'b0;
            bridge_out_neg_a_oe <= 1'b0;
            bridge_out_pos_b_oe <= 1'b0;
            bridge_out_neg_b_oe <= 1'b0;
            current_cmd_a       <= 7'h00;
            current_cmd_b       <= 7'h00;
            decay_mode_a        <= `SBC_DECAY_SLOW;
            decay_mode_b        <= `SBC_DECAY_SLOW;
        end else if (hold_home) begin
            bridge_out_pos_a_oe <= 1'b0;
            bridge_out_neg_a_oe <= 1'b0;
            bridge_out_pos_b_oe <= 1'b0;
            bridge_out_neg_b_oe <= 1'b0;
            current_cmd_a       <= 7'h00;
            current_cmd_b       <= 7'h00;
        end else if (indexer_mode) begin
            // Sign of the table current sets each bridge
            bridge_out_pos_a    <= ~cur_a[7];
            bridge_out_neg_a    <= cur_a[7];
            bridge_out_pos_b    <= ~cur_b[7];
            bridge_out_neg_b    <= cur_b[7];
            bridge_out_pos_a_oe <= ~odis_s;
            bridge_out_neg_a_oe <= ~odis_s;
            bridge_out_pos_b_oe <= ~odis_s;
            bridge_out_neg_b_oe <= ~odis_s;
            current_cmd_a       <= absval(cur_a);
            current_cmd_b       <= absval(cur_b);
            // Only the A selection counts; rising current decays slowly
            decay_mode_a <= rise_a ? `SBC_DECAY_SLOW : dec_a_s;
            decay_mode_b <= rise_b ? `SBC_DECAY_SLOW : dec_a_s;
        end else begin
            // Enabled drives by direction; disabled brakes or floats
            bridge_out_pos_a    <= en_a_s & dir_a_s;
            bridge_out_neg_a    <= en_a_s & ~dir_a_s;
            bridge_out_pos_b    <= en_b_s & dir_b_s;
            bridge_out_neg_b    <= en_b_s & ~dir_b_s;
            bridge_out_pos_a_oe <= en_a_s | ~m_hi_s;
            bridge_out_neg_a_oe <= en_a_s | ~m_hi_s;
            bridge_out_pos_b_oe <= en_b_s | ~m_hi_s;
            bridge_out_neg_b_oe <= en_b_s | ~m_hi_s;
            current_cmd_a       <= `SBC_FULL_SCALE;
            current_cmd_b       <= `SBC_FULL_SCALE;
            decay_mode_a        <= dec_a_s;
            decay_mode_b        <= dec_b_s;
        end
    end

    // AXI4-Lite write path: address and data held until both are in
    reg [ADDR_W-1:0] wa_q;
    reg              aw_held_q;
    reg              w_held_q;
    reg [31:0]       wd_q;
    reg              ws_q;
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            wa_q         <= {ADDR_W{1'b0}};
            wd_q         <= 32'h0000_0000;
            ws_q         <= 1'b0;
            ctrl_q       <= `SBC_CTRL_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SBC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                wa_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wd_q     <= s_axi_wdata;
                ws_q     <= s_axi_wstrb[0];
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa_q[7:0] == `SBC_OFF_CTRL) begin
                    s_axi_bresp <= `SBC_RESP_OKAY;
                    if (ws_q)
                        ctrl_q <= wd_q[1:0];
                end else if (wa_q[7:0] == `SBC_OFF_POSITION ||
                             wa_q[7:0] == `SBC_OFF_CURRENT ||
                             wa_q[7:0] == `SBC_OFF_PINS) begin
                    // Status registers ignore writes
                    s_axi_bresp <= `SBC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SBC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path: one read at a time, answered next cycle
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SBC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `SBC_RESP_OKAY;
            case (s_axi_araddr[7:0])
                `SBC_OFF_CTRL:
                    s_axi_rdata <= {30'h0000_0000, ctrl_q};
                `SBC_OFF_POSITION:
                    s_axi_rdata <= {21'h00_0000, res_q, 1'b0, pos_q};
                `SBC_OFF_CURRENT:
                    s_axi_rdata <= {16'h0000, cur_b, cur_a};
                `SBC_OFF_PINS:
                    s_axi_rdata <= {15'h0000, pins_s};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SBC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // sbc_top

// ===== verification/sbc_checker.sv
// Port checker for sbc_top: AXI handshakes and bridge pin relations.
// Assumes it is bound to sbc_top and sees only its ports.
module sbc_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        undervolt_n,
    input wire        bridge_out_pos_a,
    input wire        bridge_out_pos_a_oe,
    input wire        bridge_out_neg_a,
    input wire        bridge_out_neg_a_oe,
    input wire        bridge_out_pos_b,
    input wire        bridge_out_pos_b_oe,
    input wire        bridge_out_neg_b,
    input wire        bridge_out_neg_b_oe,
    input wire [6:0]  current_cmd_a,
    input wire [6:0]  current_cmd_b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Read answer comes exactly one cycle after the address is taken
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during answer");
    // Both pins of a bridge float or drive together
    a_oe_pair: assert property (
        bridge_out_pos_a_oe == bridge_out_neg_a_oe &&
        bridge_out_pos_b_oe == bridge_out_neg_b_oe) else $error("oe split");
    // A bridge never drives both pins high: that would short the winding
    a_no_short: assert property (
        !(bridge_out_pos_a && bridge_out_neg_a) &&
        !(bridge_out_pos_b && bridge_out_neg_b)) else $error("both high");
    // Sync delay is two flops plus the output register
    a_uv_off: assert property (!undervolt_n [*5] |->
        !bridge_out_pos_a_oe && !bridge_out_neg_b_oe &&
        current_cmd_a == 7'h00)
        else $error("stage live in undervoltage");
    a_cur_max: assert property (current_cmd_a <= 7'h64 &&
        current_cmd_b <= 7'h64) else $error("current above full scale");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_uv: cover property (!undervolt_n [*5]);
endmodule // sbc_checker

bind sbc_top sbc_checker sbc_checker_inst (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .undervolt_n, .bridge_out_pos_a,
    .bridge_out_pos_a_oe, .bridge_out_neg_a, .bridge_out_neg_a_oe,
    .bridge_out_pos_b, .bridge_out_pos_b_oe, .bridge_out_neg_b,
    .bridge_out_neg_b_oe, .current_cmd_a, .current_cmd_b);

// ===== verification/sbc_mcu_model.sv
// Controller model: drives step, direction and mode select pins.
// Assumes one caller at a time on the shared aclk.
module sbc_mcu_model (
    input  wire  aclk,
    output logic mode_select_hi = 1'b0,
    output logic mode_select_lo = 1'b0,
    output logic mode_select_lo_float = 1'b0,
    output logic step_pulse = 1'b0,
    output logic travel_dir = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // Selects are {hi, lo, open}; an open pin flips its stale level so
    // the floating state never rides on a leftover value
    task automatic step(input logic [2:0] s, input logic d, input int n);
        @(posedge aclk);
        mode_select_hi <= s[2];
        mode_select_lo <= s[0] ? ~mode_select_lo : s[1];
        mode_select_lo_float <= s[0];
        travel_dir <= d;
        repeat (2) @(posedge aclk);
        // Pulses last three clocks high and four low, beyond the minimum
        for (int i = 0; i < n; i++) begin
            step_pulse <= 1'b1;
            repeat (3) @(posedge aclk);
            step_pulse <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule // sbc_mcu_model

// ===== verification/tb.sv
// Self-checking bench for sbc_top: registers, phase/enable decoding and
// indexer stepping. Assumes the map and codes of sbc_regs.vh.
`include "sbc_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        winding_direction_a = 0, winding_direction_b = 0;
    logic        bridge_enable_in_a = 0, bridge_enable_in_b = 0;
    logic        output_disable_n = 0, undervolt_n = 1;
    logic [2:0]  decay_select_a = 3'h3, decay_select_b = 3'h2;
    logic        mode_select_hi, mode_select_lo, mode_select_lo_float;
    logic        step_pulse, travel_dir, bridge_out_pos_a, bridge_out_neg_a;
    logic        bridge_out_pos_b, bridge_out_neg_b, bridge_out_pos_a_oe;
    logic        bridge_out_neg_a_oe, bridge_out_pos_b_oe, bridge_out_neg_b_oe;
    logic [6:0]  current_cmd_a, current_cmd_b;
    logic [2:0]  decay_mode_a, decay_mode_b;
    logic [2:0]  sel [6] = '{3'b000, 3'b010, 3'b001, 3'b100, 3'b110, 3'b101};
    int          num_errors = 0, checked = 0;
    wire  [7:0]  br = {bridge_out_pos_a, bridge_out_pos_a_oe, bridge_out_neg_a,
        bridge_out_neg_a_oe, bridge_out_pos_b, bridge_out_pos_b_oe,
        bridge_out_neg_b, bridge_out_neg_b_oe};

    sbc_top sbc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .winding_direction_a,
        .winding_direction_b, .bridge_enable_in_a, .bridge_enable_in_b,
        .mode_select_hi, .mode_select_lo, .mode_select_lo_float, .step_pulse,
        .travel_dir, .output_disable_n, .undervolt_n, .decay_select_a,
        .decay_select_b, .bridge_out_pos_a, .bridge_out_pos_a_oe,
        .bridge_out_neg_a, .bridge_out_neg_a_oe, .bridge_out_pos_b,
        .bridge_out_pos_b_oe, .bridge_out_neg_b, .bridge_out_neg_b_oe,
        .current_cmd_a, .current_cmd_b, .decay_mode_a, .decay_mode_b);
    sbc_mcu_model sbc_mcu_model_inst (.aclk, .mode_select_hi, .mode_select_lo,
        .mode_select_lo_float, .step_pulse, .travel_dir);

    // 40 MHz clock
    always #12.5 aclk = ~aclk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Four-state compare so an unknown never counts as a match
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        num_errors++;
        $display("unexpected hang at %0t", $time);
        end_of_test();
    endtask
    // Address and data go out together; each drops once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) hang();
        check(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) hang();
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
    endtask
    // Pins pass two sync flops and an output register
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask
    function automatic logic [31:0] pos(input int r, input int p);
        return (r << 8) | (p & 127);
    endfunction

    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        rd(`SBC_OFF_CTRL, 32'h0, `SBC_RESP_OKAY);
        rd(`SBC_OFF_POSITION, pos(0, 16), `SBC_RESP_OKAY);
        rd(8'h10, 32'h0, `SBC_RESP_SLVERR);
        wr(8'h10, 32'h1, `SBC_RESP_SLVERR);
        wr(`SBC_OFF_POSITION, 32'h7f, `SBC_RESP_OKAY);
        rd(`SBC_OFF_POSITION, pos(0, 16), `SBC_RESP_OKAY);
        // Phase/enable: every mode_select_hi, enable and direction combination
        for (int i = 0; i < 8; i++) begin
            sbc_mcu_model_inst.step({i[2], 2'b00}, 1'b1, 0);
            bridge_enable_in_a <= i[1];
            bridge_enable_in_b <= i[1];
            winding_direction_a <= i[0];
            winding_direction_b <= ~i[0];
            settle();
            if (i[1]) check(br, {i[0], 1'b1, ~i[0], 1'b1, ~i[0], 1'b1,
                i[0], 1'b1});
            else if (i[2]) check(br & 8'h55, 8'h00);
            else check(br, 8'h55);
        end
        check({current_cmd_a, decay_mode_b}, {7'h64, decay_select_b});
        rd(`SBC_OFF_PINS, 32'h9d1d, `SBC_RESP_OKAY);
        // Indexer: one step up and back at each resolution from home
        wr(`SBC_OFF_CTRL, 32'h1, `SBC_RESP_OKAY);
        for (int k = 0; k < 6; k++) begin
            sbc_mcu_model_inst.step(sel[k], 1'b1, 1);
            rd(`SBC_OFF_POSITION, pos(k,16+(32>>k)), `SBC_RESP_OKAY);
            sbc_mcu_model_inst.step(sel[k], 1'b0, 1);
            rd(`SBC_OFF_POSITION, pos(k, 16), `SBC_RESP_OKAY);
        end
        sbc_mcu_model_inst.step(3'b101, 1'b1, 1);
        check({current_cmd_a, current_cmd_b}, {7'h43, 7'h4a});
        check({decay_mode_a, decay_mode_b}, {decay_select_a, 3'h0});
        check(br, 8'hdd);
        // Coarser steps from an off-grid point land on the new grid
        sbc_mcu_model_inst.step(3'b010, 1'b1, 1);
        rd(`SBC_OFF_POSITION, pos(1, 32), `SBC_RESP_OKAY);
        check({current_cmd_a, current_cmd_b}, {7'h00, 7'h64});
        sbc_mcu_model_inst.step(3'b000, 1'b1, 1);
        rd(`SBC_OFF_POSITION, pos(0, 48), `SBC_RESP_OKAY);
        check(current_cmd_a, 7'h47);
        check(br, 8'h7d);
        rd(`SBC_OFF_CURRENT, 32'h47b9, `SBC_RESP_OKAY);
        sbc_mcu_model_inst.step(3'b000, 1'b0, 2);
        rd(`SBC_OFF_POSITION, pos(0, 112), `SBC_RESP_OKAY);
        // Disabled stage still steps
        output_disable_n <= 1'b1;
        sbc_mcu_model_inst.step(3'b000, 1'b1, 1);
        check(br & 8'h55, 8'h00);
        rd(`SBC_OFF_POSITION, pos(0, 16), `SBC_RESP_OKAY);
        output_disable_n <= 1'b0;
        // Sleep and undervoltage both send the indexer home
        sbc_mcu_model_inst.step(3'b000, 1'b1, 1);
        wr(`SBC_OFF_CTRL, 32'h3, `SBC_RESP_OKAY);
        settle();
        check({br & 8'h55, current_cmd_a}, 15'h0);
        wr(`SBC_OFF_CTRL, 32'h1, `SBC_RESP_OKAY);
        rd(`SBC_OFF_POSITION, pos(0, 16), `SBC_RESP_OKAY);
        sbc_mcu_model_inst.step(3'b000, 1'b1, 1);
        undervolt_n <= 1'b0;
        settle();
        check({br & 8'h55, current_cmd_a}, 15'h0);
        undervolt_n <= 1'b1;
        settle();
        rd(`SBC_OFF_POSITION, pos(0, 16), `SBC_RESP_OKAY);
        end_of_test();
    end
endmodule // tb
